// File: hw/pire_regs.svh
// Register offsets, field masks and reset values of the interrupt flag block
`ifndef PIRE_REGS_SVH
`define PIRE_REGS_SVH

`define PIRE_ADDR_W        8
`define PIRE_OFF_EN4       8'h00
`define PIRE_OFF_REQ1      8'h04
`define PIRE_OFF_REQ2      8'h08
`define PIRE_OFF_REQ3      8'h0c
`define PIRE_OFF_IRQ_STAT  8'h10
`define PIRE_OFF_IRQ_MASK  8'h14
`define PIRE_OFF_PEND      8'h18

`define PIRE_EN4_IMPL      8'h03
`define PIRE_EN4_COLL_BIT  1
`define PIRE_EN4_XFER_BIT  0
`define PIRE_REQ1_IMPL     8'hff
`define PIRE_REQ1_HWLVL    8'h30
`define PIRE_REQ2_IMPL     8'hf9
`define PIRE_REQ2_IMPL_SM  8'hb9
`define PIRE_REQ3_IMPL     8'h3a
`define PIRE_NO_BITS       8'h00
`define PIRE_REG_RST       8'h00
`define PIRE_WORD_RST      32'h00000000

`define PIRE_IST_W         4
`define PIRE_IST_RST       4'h0
`define PIRE_IST_REQ1      0
`define PIRE_IST_REQ2      1
`define PIRE_IST_REQ3      2
`define PIRE_IST_BUSERR    3

`define PIRE_HI_ZERO       24'h000000
`define PIRE_RESP_OKAY     2'b00
`define PIRE_RESP_SLVERR   2'b10

`endif

// File: hw/pire_pkg.sv
// Types shared by the interrupt flag block
package pire_pkg;

  // Event pulses per request register
  typedef struct packed {
    logic [7:0] r3;
    logic [7:0] r2;
    logic [7:0] r1;
  } pire_evt_t;

  // Enables of the first three request registers, held elsewhere
  typedef struct packed {
    logic [7:0] e3;
    logic [7:0] e2;
    logic [7:0] e1;
  } pire_en_t;

  // Second serial port flags, held elsewhere
  typedef struct packed {
    logic collision;
    logic transfer;
  } pire_ser2_t;

  // Write channel states
  typedef enum logic [1:0] {
    PIRE_WR_IDLE = 2'b00,
    PIRE_WR_RESP = 2'b01
  } pire_wr_st_t;

endpackage : pire_pkg

// File: hw/pire_top.sv
// Peripheral interrupt enable and request registers behind an AXI4-Lite slave
//
// Summary of operation
// - Events set request flags regardless of enables
// - Enable bit 1 gates serial2 collision
// - Enable bit 0 gates serial2 transfer
// - Enable bits 7..2 read zero, ignore writes
// - Request 1 holds eight pending source flags
// - Request 1 bits 5,4 are read-only
// - Request 2 flags; bits 2,1 read zero
// - Request 3 flags; bits 7,6,2,0 zero
// - All implemented bits reset to zero
// - Enable 4 and comparator2 only large variant
// - Peripheral irq needs core peripheral enable
`timescale 1ns/100ps
`include "pire_regs.svh"

module pire_top
  import pire_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Peripheral events and external enables
  input  wire pire_evt_t   event_in,
  input  wire pire_en_t    enable_in,
  input  wire pire_ser2_t  serial2_flags,
  input  wire logic        periph_irq_enable,
  // Interrupt outputs
  output logic             periph_irq,
  output logic             irq
);

  localparam logic [7:0] REQ2_IMPL = LARGE_VARIANT ? `PIRE_REQ2_IMPL : `PIRE_REQ2_IMPL_SM;
  localparam logic [7:0] EN4_IMPL  = LARGE_VARIANT ? `PIRE_EN4_IMPL : `PIRE_NO_BITS;

  localparam logic [7:0] REQ_OFF   [3] = '{`PIRE_OFF_REQ1, `PIRE_OFF_REQ2, `PIRE_OFF_REQ3};
  localparam logic [7:0] REQ_IMPL  [3] = '{`PIRE_REQ1_IMPL, REQ2_IMPL, `PIRE_REQ3_IMPL};
  localparam logic [7:0] REQ_HWLVL [3] = '{`PIRE_REQ1_HWLVL, `PIRE_NO_BITS, `PIRE_NO_BITS};

  // Registers
  logic [7:0]            req_r [3];
  logic [7:0]            req_nxt [3];
  logic [7:0]            ev_a [3];
  logic [7:0]            en_a [3];
  logic [7:0]            en4_r;
  logic [`PIRE_IST_W-1:0] ist_r;
  logic [`PIRE_IST_W-1:0] imask_r;
  logic [`PIRE_IST_W-1:0] ist_set;

  // Bus slave state
  pire_wr_st_t           wr_st_r;
  logic                  aw_full_r;
  logic                  w_full_r;
  logic [31:0]           aw_addr_r;
  logic [31:0]           w_data_r;
  logic                  w_lane0_r;
  logic                  awready_r;
  logic                  wready_r;
  logic                  bvalid_r;
  logic [1:0]            bresp_r;
  logic                  arready_r;
  logic                  rvalid_r;
  logic [31:0]           rdata_r;
  logic [1:0]            rresp_r;
  logic                  pirq_r;
  logic                  irq_r;

  // Handshake terms
  logic                  aw_take;
  logic                  w_take;
  logic                  wr_do;
  logic                  wr_hit_ok;
  logic                  ar_take;
  logic [7:0]            wr_off;
  logic [7:0]            wr_byte;
  logic                  wr_lane;
  logic [7:0]            rd_byte;
  logic                  rd_ok;
  logic [7:0]            pend_sum;
  logic                  any_pend;

  assign ev_a[0] = event_in.r1;
  assign ev_a[1] = event_in.r2;
  assign ev_a[2] = event_in.r3;
  assign en_a[0] = enable_in.e1;
  assign en_a[1] = enable_in.e2;
  assign en_a[2] = enable_in.e3;

  assign aw_take = s_axi_awvalid & awready_r;
  assign w_take  = s_axi_wvalid & wready_r;
  assign ar_take = s_axi_arvalid & arready_r;
  // Address and data may arrive in either order; commit once both are held
  assign wr_do   = aw_full_r & w_full_r & (wr_st_r == PIRE_WR_IDLE);
  assign wr_off  = aw_addr_r[7:0];
  assign wr_byte = w_data_r[7:0];
  assign wr_lane = w_lane0_r;

  // Decode of a write target, upper address bits must be zero
  always_comb begin
    wr_hit_ok = 1'b0;
    if (aw_addr_r[31:8] == `PIRE_HI_ZERO) begin
      case (wr_off)
        `PIRE_OFF_EN4,
        `PIRE_OFF_REQ1,
        `PIRE_OFF_REQ2,
        `PIRE_OFF_REQ3,
        `PIRE_OFF_IRQ_STAT,
        `PIRE_OFF_IRQ_MASK,
        `PIRE_OFF_PEND: wr_hit_ok = 1'b1;
        default:        wr_hit_ok = 1'b0;
      endcase
    end
  end

  // Request flags, one entry per request register
  generate
    for (genvar i = 0; i < 3; i++) begin : g_req
      logic       hit;
      logic [7:0] wmask;
      assign hit   = wr_do & wr_lane & (wr_off == REQ_OFF[i]) &
                     (aw_addr_r[31:8] == `PIRE_HI_ZERO);
      assign wmask = REQ_IMPL[i] & ~REQ_HWLVL[i];
      always_comb begin
        req_nxt[i] = ((hit ? (wr_byte & wmask) : (req_r[i] & wmask)) | (ev_a[i] & wmask))
                     | (ev_a[i] & REQ_HWLVL[i] & REQ_IMPL[i]);
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          req_r[i] <= `PIRE_REG_RST;
        end else begin
          req_r[i] <= req_nxt[i];
        end
      end
      // Hardware sets a flag that software may not have seen yet
      assign ist_set[i] = |(ev_a[i] & REQ_IMPL[i] & ~req_r[i]);
    end
  endgenerate

  assign ist_set[`PIRE_IST_BUSERR] = (wr_do & ~wr_hit_ok) | (ar_take & ~rd_ok);

  // Fourth enable register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en4_r <= `PIRE_REG_RST;
    end else if (wr_do && wr_lane && wr_hit_ok && wr_off == `PIRE_OFF_EN4) begin
      en4_r <= wr_byte & EN4_IMPL;
    end
  end

  // Event status, write one to clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_r <= `PIRE_IST_RST;
    end else if (wr_do && wr_lane && wr_hit_ok && wr_off == `PIRE_OFF_IRQ_STAT) begin
      ist_r <= (ist_r & ~wr_byte[`PIRE_IST_W-1:0]) | ist_set;
    end else begin
      ist_r <= ist_r | ist_set;
    end
  end

  // Event mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      imask_r <= `PIRE_IST_RST;
    end else if (wr_do && wr_lane && wr_hit_ok && wr_off == `PIRE_OFF_IRQ_MASK) begin
      imask_r <= wr_byte[`PIRE_IST_W-1:0];
    end
  end

  // Pending summary per register; index 3 is the second serial port
  always_comb begin
    pend_sum[0] = |(req_r[0] & en_a[0]);
    pend_sum[1] = |(req_r[1] & en_a[1] & REQ2_IMPL);
    pend_sum[2] = |(req_r[2] & en_a[2] & `PIRE_REQ3_IMPL);
    pend_sum[3] = (serial2_flags.collision & en4_r[`PIRE_EN4_COLL_BIT]) |
                  (serial2_flags.transfer & en4_r[`PIRE_EN4_XFER_BIT]);
    pend_sum[7:4] = 4'h0;
    any_pend = |pend_sum;
  end

  // Interrupt outputs are registered, one cycle behind the flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pirq_r <= 1'b0;
      irq_r  <= 1'b0;
    end else begin
      pirq_r <= periph_irq_enable & any_pend;
      irq_r  <= |(ist_r & imask_r);
    end
  end

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= `PIRE_WORD_RST;
      awready_r <= 1'b0;
    end else if (aw_take) begin
      aw_full_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
      awready_r <= 1'b0;
    end else if (wr_do) begin
      aw_full_r <= 1'b0;
    end else if (!aw_full_r && wr_st_r == PIRE_WR_IDLE) begin
      awready_r <= 1'b1;
    end
  end

  // Write data channel; only byte lane 0 carries register bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r  <= 1'b0;
      w_data_r  <= `PIRE_WORD_RST;
      w_lane0_r <= 1'b0;
      wready_r  <= 1'b0;
    end else if (w_take) begin
      w_full_r  <= 1'b1;
      w_data_r  <= s_axi_wdata;
      w_lane0_r <= s_axi_wstrb[0];
      wready_r  <= 1'b0;
    end else if (wr_do) begin
      w_full_r  <= 1'b0;
    end else if (!w_full_r && wr_st_r == PIRE_WR_IDLE) begin
      wready_r  <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st_r  <= PIRE_WR_IDLE;
      bvalid_r <= 1'b0;
      bresp_r  <= `PIRE_RESP_OKAY;
    end else begin
      case (wr_st_r)
        PIRE_WR_IDLE: begin
          if (wr_do) begin
            wr_st_r  <= PIRE_WR_RESP;
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit_ok ? `PIRE_RESP_OKAY : `PIRE_RESP_SLVERR;
          end
        end
        PIRE_WR_RESP: begin
          if (s_axi_bready) begin
            wr_st_r  <= PIRE_WR_IDLE;
            bvalid_r <= 1'b0;
          end
        end
        default: begin
          wr_st_r  <= PIRE_WR_IDLE;
          bvalid_r <= 1'b0;
        end
      endcase
    end
  end

  // Read decode; unimplemented bits come back as zero
  always_comb begin
    rd_byte = `PIRE_REG_RST;
    rd_ok   = s_axi_araddr[31:8] == `PIRE_HI_ZERO;
    case (s_axi_araddr[7:0])
      `PIRE_OFF_EN4:      rd_byte = en4_r;
      `PIRE_OFF_REQ1:     rd_byte = req_r[0];
      `PIRE_OFF_REQ2:     rd_byte = req_r[1];
      `PIRE_OFF_REQ3:     rd_byte = req_r[2];
      `PIRE_OFF_IRQ_STAT: rd_byte = {{(8-`PIRE_IST_W){1'b0}}, ist_r};
      `PIRE_OFF_IRQ_MASK: rd_byte = {{(8-`PIRE_IST_W){1'b0}}, imask_r};
      `PIRE_OFF_PEND:     rd_byte = pend_sum;
      default:            rd_ok   = 1'b0;
    endcase
  end

  // Read channel; one read at a time, answer one cycle after the take
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= `PIRE_WORD_RST;
      rresp_r   <= `PIRE_RESP_OKAY;
    end else if (ar_take) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= {`PIRE_HI_ZERO, rd_ok ? rd_byte : `PIRE_REG_RST};
      rresp_r   <= rd_ok ? `PIRE_RESP_OKAY : `PIRE_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r  <= 1'b0;
    end else if (!rvalid_r) begin
      arready_r <= 1'b1;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign periph_irq    = pirq_r;
  assign irq           = irq_r;

endmodule : pire_top

// File: tb/pire_checker.sv
// Bus and interrupt assertions on the flag block ports
`timescale 1ns/100ps
module pire_checker
  import pire_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Read channels
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Sources and interrupt
  input wire pire_evt_t   event_in,
  input wire pire_en_t    enable_in,
  input wire logic        periph_irq_enable,
  input wire logic        periph_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_bad_addr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[31:8] != 24'h000000
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("bad address accepted");
  a_ready_up: assert property ($rose(aresetn) |=> s_axi_arready)
    else $error("no ready after reset");
  a_rd_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  a_irq_gate: assert property (!periph_irq_enable |=> !periph_irq)
    else $error("irq without peripheral enable");
  a_flag_irq: assert property ((event_in.r1[0] && enable_in.e1[0] && periph_irq_enable) ##1
    (enable_in.e1[0] && periph_irq_enable) |=> periph_irq) else $error("enabled event lost");
endmodule : pire_checker

// File: tb/pire_src_model.sv
// Peripheral event source model feeding the flag block
`timescale 1ns/100ps
module pire_src_model
  import pire_pkg::*;
(
  // Clock and control
  input  wire logic       aclk,
  input  wire logic       fire,
  input  wire pire_evt_t  pat,
  input  wire logic [1:0] lvl,
  // Events
  output pire_evt_t       event_in
);
  // Registered, so sources answer a cycle late; USART pair are levels
  always_ff @(posedge aclk) begin
    event_in <= fire ? pat : 24'h000000;
    event_in.r1[5:4] <= lvl;
  end
endmodule : pire_src_model

// File: tb/pire_top_tb.sv
// Self-checking bench of the interrupt flag block
`timescale 1ns/100ps
module pire_top_tb
  import pire_pkg::*;
;
  // Stimulus
  logic        aclk = 1'b0, aresetn = 1'b0, fire = 1'b0, periph_irq_enable = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [1:0]  lvl = 2'h0;
  pire_evt_t   pat = 24'h000000;
  pire_en_t    enable_in = 24'h000000;
  pire_ser2_t  serial2_flags = 2'h0;
  // Observed
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, periph_irq, irq;
  logic [31:0] s_axi_rdata, rd_d, rdata_sm, rd_s;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  pire_evt_t   event_in;
  int          errors, check_count, cycles;
  // Address, write data, read-back value
  logic [23:0] rows [9] = '{24'h00ff03, 24'h000000, 24'h04ffcf, 24'h040000, 24'h08fff9,
                            24'h080000, 24'h0cff3a, 24'h0c0000, 24'h18ff00};
  // Serial2 flags, enable4 bits, expected irq
  logic [4:0]  s2rows [4] = '{5'b10000, 5'b10101, 5'b01100, 5'b01011};

  pire_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .event_in, .enable_in, .serial2_flags, .periph_irq_enable,
    .periph_irq, .irq);
  pire_src_model src (.aclk, .fire, .pat, .lvl, .event_in);
  // Small variant shares the bus; its timing matches, only its read data is kept
  pire_top #(.LARGE_VARIANT(1'b0)) DUT_SM (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready(),
    .s_axi_rdata(rdata_sm), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready, .event_in,
    .enable_in, .serial2_flags, .periph_irq_enable, .periph_irq(), .irq());

  always #5 aclk = ~aclk;

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // Each channel is released at its own handshake edge
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask : wr

  // Late rready so the held read answer is exercised
  task automatic rc(input logic [31:0] a, input logic [7:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    rd_d = s_axi_rdata;
    rd_s = rdata_sm;
    resp = s_axi_rresp;
    chk($sformatf("read %h", a), rd_d, {24'h000000, e});
  endtask : rc

  task automatic pulse(input pire_evt_t p);
    @(posedge aclk);
    fire <= 1'b1;
    pat <= p;
    @(posedge aclk);
    fire <= 1'b0;
    cyc(3);
  endtask : pulse

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      wr({24'h000000, rows[i][23:16]}, rows[i][15:8]);
      rc({24'h000000, rows[i][23:16]}, rows[i][7:0]); // access
    end
    $display("Test register access done");
    pulse(24'hffffcf);
    rc(32'h4, 8'hcf); // set by events
    rc(32'h8, 8'hf9); // set by events
    rc(32'hc, 8'h3a); // set by events
    periph_irq_enable <= 1'b1;
    cyc(3);
    chk("periph_irq", periph_irq, 32'h0); // flag alone
    wr(32'h4, 8'h00); // clear before enable
    enable_in <= 24'h000001;
    cyc(3);
    chk("periph_irq", periph_irq, 32'h0); // stale flag gone
    pulse(24'h000001);
    chk("periph_irq", periph_irq, 32'h1); // enabled flag
    periph_irq_enable <= 1'b0;
    cyc(3);
    chk("periph_irq", periph_irq, 32'h0); // gated off
    enable_in <= 24'h000000;
    $display("Test events done");
    lvl <= 2'b11;
    cyc(3);
    wr(32'h4, 8'h00); // clears bit 0; bits 5,4 keep the level
    rc(32'h4, 8'h30); // follows level
    lvl <= 2'b00;
    cyc(3);
    rc(32'h4, 8'h00); // follows level
    $display("Test usart levels done");
    periph_irq_enable <= 1'b1;
    foreach (s2rows[i]) begin
      serial2_flags <= s2rows[i][4:3];
      wr(32'h0, {6'h00, s2rows[i][2:1]});
      cyc(3);
      chk("periph_irq", periph_irq, {31'h0, s2rows[i][0]}); // serial2 gating
    end
    serial2_flags <= 2'h0;
    periph_irq_enable <= 1'b0;
    $display("Test serial2 enables done");
    wr(32'h10, 8'h0f);
    wr(32'h100, 8'hff);
    chk("bresp", resp, 32'h2);
    rc(32'h100, 8'h00);
    chk("rresp", resp, 32'h2);
    wr(32'h14, 8'h08);
    cyc(2);
    chk("irq", irq, 32'h1);
    wr(32'h14, 8'h00);
    cyc(2);
    chk("irq", irq, 32'h0);
    wr(32'h14, 8'h08);
    wr(32'h10, 8'h08);
    cyc(2);
    chk("irq", irq, 32'h0);
    $display("Test bus error interrupt done");
    wr(32'h0, 8'h03);
    pulse(24'hffffff);
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) rc(32'(i * 4), 8'h00); // cleared by reset
    $display("Test reset done");
    s_axi_wstrb <= 4'he;
    wr(32'h0, 8'h03);
    s_axi_wstrb <= 4'hf;
    chk("bresp", resp, 32'h0);
    rc(32'h0, 8'h00); // no lane 0, no write
    wr(32'h0, 8'hff);
    rc(32'h0, 8'h03); // large variant enable 4
    chk("small enable4", rd_s, 32'h0);
    wr(32'h8, 8'hff);
    rc(32'h8, 8'hf9); // large variant request 2
    chk("small request2", rd_s, 32'hb9);
    $display("Test lanes and variants done");
    stop_test();
  end
endmodule : pire_top_tb

bind pire_top pire_checker u_chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .event_in,
  .enable_in, .periph_irq_enable, .periph_irq);
